// File: design/dcpwm_pkg.sv
// Package for the dual channel pulse width generator
package dcpwm_pkg;

   // ==========================================================
   // Register word offsets within one eight-word control block
   localparam logic [2:0] dcpwm_off_freq_sel  = 3'h0;
   localparam logic [2:0] dcpwm_off_duty      = 3'h1;
   localparam logic [2:0] dcpwm_off_cnt_en    = 3'h2;
   localparam logic [2:0] dcpwm_off_pre_high  = 3'h3;
   localparam logic [2:0] dcpwm_off_pre_low   = 3'h4;
   localparam logic [2:0] dcpwm_off_cur_high  = 3'h5;
   localparam logic [2:0] dcpwm_off_cur_low   = 3'h6;
   localparam logic [2:0] dcpwm_off_err       = 3'h7;
   localparam int         dcpwm_block_words   = 8;
   // Channel select bit position in the byte address; status word of both channels
   localparam int          dcpwm_chan_bit     = 5;
   localparam logic [11:0] dcpwm_addr_status  = 12'h040;
   // Status bit positions within a channel group
   localparam int dcpwm_st_running  = 0;
   localparam int dcpwm_st_done     = 1;
   localparam int dcpwm_st_overflow = 2;
   localparam int dcpwm_st_group    = 4;

   // ==========================================================
   // Reset values
   localparam logic [15:0] dcpwm_rst_word = 16'h0000;

   // ==========================================================
   // Limits
   localparam logic [15:0] dcpwm_freq_codes = 16'h0003;
   localparam logic [15:0] dcpwm_duty_max   = 16'h0064;
   localparam logic [31:0] dcpwm_preset_max = 32'h05f5e100;

   // ==========================================================
   // Timing: periods in microseconds, clock rate in Hz
   localparam longint dcpwm_clk_hz       = 40000000;
   localparam longint dcpwm_period0_us   = 146840;
   localparam longint dcpwm_period1_us   = 36680;
   localparam longint dcpwm_period2_us   = 4590;
   localparam logic [22:0] dcpwm_period0_cyc = 23'(dcpwm_period0_us * dcpwm_clk_hz / 1000000);
   localparam logic [22:0] dcpwm_period1_cyc = 23'(dcpwm_period1_us * dcpwm_clk_hz / 1000000);
   localparam logic [22:0] dcpwm_period2_cyc = 23'(dcpwm_period2_us * dcpwm_clk_hz / 1000000);

   // ==========================================================
   // Error codes
   typedef enum logic [15:0] {
      dcpwm_err_none     = 16'h0000,
      dcpwm_err_freq     = 16'h0001,
      dcpwm_err_duty     = 16'h0002,
      dcpwm_err_cnt_en   = 16'h0003,
      dcpwm_err_preset   = 16'h0004,
      dcpwm_err_chan2cnt = 16'h0005
   } dcpwm_err_t;

   // ==========================================================
   // Channel state machine
   typedef enum logic [2:0] {
      dcpwm_idle = 3'b001,
      dcpwm_run  = 3'b010,
      dcpwm_stop = 3'b100
   } dcpwm_state_t;

   // ==========================================================
   // Per-channel state
   typedef struct packed {
      dcpwm_state_t state;
      logic [15:0]  freq_sel;
      logic [15:0]  duty;
      logic [15:0]  cnt_en;
      logic [15:0]  pre_high;
      logic [15:0]  pre_low;
      logic [31:0]  cur_count;
      dcpwm_err_t   err;
      logic [22:0]  phase;
      logic [22:0]  period;
      logic [22:0]  high_cyc;
      logic         start_prev;
      logic         running;
      logic         done;
      logic         overflow;
      logic         pulse_out;
   } dcpwm_chan_t;

   // ==========================================================
   // AXI4-Lite slave side state
   typedef struct packed {
      logic        aw_held;
      logic [11:0] aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } dcpwm_bus_t;

   typedef struct packed {
      dcpwm_chan_t [1:0] chan;
      dcpwm_bus_t        bus;
   } dcpwm_state_all_t;

endpackage

// File: design/dcpwm_top.sv
// Dual channel pulse width generator with an AXI4-Lite register slave
`timescale 1ns/1ps
// How it works
// - Frequency code 0, 1, 2 selects 6.81, 27.26 or 217.86 Hz.
// - Periods are 146.84 ms, 36.68 ms and 4.59 ms for codes 0 to 2.
// - High time is the duty word percent of the period; duty 1 to 100.
// - First channel drives first output, second channel drives second output.
// - Count-enable 0 disables, 1 enables; only first channel may count.
// - With counting on, first channel emits exactly the preset pulses then stops.
// - Without counting, a channel pulses while its start input stays high.
// - Preset is high word then low word, valid 1 to 100,000,000.
// - First channel publishes pulses output so far as high and low words.
// - Each start rising edge validates operands and stores an error code 0 to 5.
// - Current count and error words are read-only; only hardware updates them.
// - Each channel control block is eight consecutive words.
// - Running flag is high while pulsing, clears on start removal or preset reached.
// - Done flag sets when output stops or completes, clears on a new start.
// - Overflow sets if first channel emits more than the preset; clears on start.
// - Error codes: 1 frequency, 2 duty, 3 count-enable, 4 preset, 5 second-channel count.
module dcpwm_top
   import dcpwm_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              reset,
   // Channel start inputs
   input  wire logic [1:0]        start_in,
   // Pulse outputs
   output logic                   first_pulse_output,
   output logic                   second_pulse_output,
   // Status flags, three per channel
   output logic [1:0]             running_flag,
   output logic [1:0]             done_flag,
   output logic [1:0]             overflow_flag,
   // AXI4-Lite write address
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   // AXI4-Lite write response
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   // AXI4-Lite read data
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp
);

   if (ADDR_W != 12)
   begin
      $error("ADDR_W must be 12");
   end

   dcpwm_state_all_t st_reg;
   dcpwm_state_all_t st_next;

   // ==========================================================
   // Helpers
   function automatic logic [22:0] period_of(input logic [15:0] code);
      logic [22:0] p;
      p = dcpwm_period2_cyc;
      if (code == 16'h0000)
         p = dcpwm_period0_cyc;
      else if (code == 16'h0001)
         p = dcpwm_period1_cyc;
      return p;
   endfunction

   function automatic logic [22:0] high_of(input logic [22:0] per, input logic [15:0] duty);
      logic [31:0] prod;
      prod = 32'(per) * 32'(duty[6:0]) + 32'd50;
      // rounded period times duty over 100
      return 23'(prod / 32'd100);
   endfunction

   function automatic dcpwm_err_t check_ops(input dcpwm_chan_t c, input logic second);
      logic [31:0] pre;
      dcpwm_err_t  e;
      pre = {c.pre_high, c.pre_low};
      e   = dcpwm_err_none;
      if (c.freq_sel >= dcpwm_freq_codes)
         e = dcpwm_err_freq;
      else if (c.duty == 16'h0000 || c.duty > dcpwm_duty_max)
         e = dcpwm_err_duty;
      else if (c.cnt_en > 16'h0001)
         e = dcpwm_err_cnt_en;
      else if (c.cnt_en == 16'h0001 && second)
         e = dcpwm_err_chan2cnt;
      else if (c.cnt_en == 16'h0001 && (pre == 32'h0 || pre > dcpwm_preset_max))
         e = dcpwm_err_preset;
      return e;
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // ==========================================================
   // Next state
   always_comb
   begin
      logic        wr_go;
      logic        rd_go;
      logic        ch;
      logic [2:0]  wd;
      logic [31:0] rd;
      logic        bad;
      logic [31:0] pre;
      st_next = st_reg;
      wr_go   = 1'b0;
      rd_go   = 1'b0;
      ch      = 1'b0;
      wd      = 3'h0;
      rd      = 32'h0;
      bad     = 1'b0;
      pre     = 32'h0;

      // Channel engines
      for (int i = 0; i < 2; i++)
      begin
         st_next.chan[i].start_prev = start_in[i];
         pre = {st_reg.chan[i].pre_high, st_reg.chan[i].pre_low};
         st_next.chan[i].high_cyc = high_of(period_of(st_reg.chan[i].freq_sel), st_reg.chan[i].duty);
         case (st_reg.chan[i].state)
            dcpwm_idle, dcpwm_stop:
            begin
               st_next.chan[i].pulse_out = 1'b0;
               if (start_in[i] && !st_reg.chan[i].start_prev)
               begin
                  st_next.chan[i].err      = check_ops(st_reg.chan[i], i == 1);
                  st_next.chan[i].done     = 1'b0;
                  st_next.chan[i].overflow = 1'b0;
                  st_next.chan[i].cur_count = 32'h0;
                  if (check_ops(st_reg.chan[i], i == 1) == dcpwm_err_none)
                  begin
                     st_next.chan[i].state   = dcpwm_run;
                     st_next.chan[i].running = 1'b1;
                     st_next.chan[i].phase   = 23'h0;
                     st_next.chan[i].period  = period_of(st_reg.chan[i].freq_sel);
                  end
                  else
                  begin
                     st_next.chan[i].state = dcpwm_stop;
                  end
               end
            end
            dcpwm_run:
            begin
               // stop at once on start low
               if (!start_in[i])
               begin
                  st_next.chan[i].state     = dcpwm_stop;
                  st_next.chan[i].pulse_out = 1'b0;
                  st_next.chan[i].running   = 1'b0;
                  st_next.chan[i].done      = 1'b1;
               end
               else
               begin
                  // high for duty part of period
                  st_next.chan[i].pulse_out = st_reg.chan[i].phase < st_next.chan[i].high_cyc;
                  if (st_reg.chan[i].phase == st_reg.chan[i].period - 23'h1)
                  begin
                     st_next.chan[i].phase  = 23'h0;
                     st_next.chan[i].period = period_of(st_reg.chan[i].freq_sel);
                     st_next.chan[i].cur_count = st_reg.chan[i].cur_count + 32'h1;
                     if (st_reg.chan[i].cnt_en == 16'h0001 && st_reg.chan[i].cur_count + 32'h1 >= pre)
                     begin
                        st_next.chan[i].state     = dcpwm_stop;
                        st_next.chan[i].pulse_out = 1'b0;
                        st_next.chan[i].running   = 1'b0;
                        st_next.chan[i].done      = 1'b1;
                        st_next.chan[i].overflow  = st_reg.chan[i].cur_count + 32'h1 > pre;
                     end
                  end
                  else
                     st_next.chan[i].phase = st_reg.chan[i].phase + 23'h1;
               end
            end
            default:
               st_next.chan[i].state = dcpwm_idle;
         endcase
      end

      // AXI4-Lite write side
      if (s_axi_awvalid && !st_reg.bus.aw_held)
      begin
         st_next.bus.aw_held = 1'b1;
         st_next.bus.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_reg.bus.w_held)
      begin
         st_next.bus.w_held = 1'b1;
         st_next.bus.w_data = s_axi_wdata;
         st_next.bus.w_strb = s_axi_wstrb;
      end
      if (st_reg.bus.bvalid && s_axi_bready)
         st_next.bus.bvalid = 1'b0;
      wr_go = st_reg.bus.aw_held && st_reg.bus.w_held && !st_reg.bus.bvalid;
      if (wr_go)
      begin
         st_next.bus.aw_held = 1'b0;
         st_next.bus.w_held  = 1'b0;
         st_next.bus.bvalid  = 1'b1;
         st_next.bus.bresp   = 2'b00;
         ch  = st_reg.bus.aw_addr[dcpwm_chan_bit];
         wd  = st_reg.bus.aw_addr[4:2];
         bad = st_reg.bus.aw_addr[11:6] != 6'h0 || st_reg.bus.aw_addr[1:0] != 2'b00;
         // count and error words ignore writes
         if (bad)
            st_next.bus.bresp = 2'b10;
         else if (wd == dcpwm_off_freq_sel)
            st_next.chan[ch].freq_sel = merge16(st_reg.chan[ch].freq_sel, st_reg.bus.w_data, st_reg.bus.w_strb);
         else if (wd == dcpwm_off_duty)
            st_next.chan[ch].duty = merge16(st_reg.chan[ch].duty, st_reg.bus.w_data, st_reg.bus.w_strb);
         else if (wd == dcpwm_off_cnt_en)
            st_next.chan[ch].cnt_en = merge16(st_reg.chan[ch].cnt_en, st_reg.bus.w_data, st_reg.bus.w_strb);
         else if (wd == dcpwm_off_pre_high)
            st_next.chan[ch].pre_high = merge16(st_reg.chan[ch].pre_high, st_reg.bus.w_data, st_reg.bus.w_strb);
         else if (wd == dcpwm_off_pre_low)
            st_next.chan[ch].pre_low = merge16(st_reg.chan[ch].pre_low, st_reg.bus.w_data, st_reg.bus.w_strb);
      end

      // AXI4-Lite read side
      if (st_reg.bus.rvalid && s_axi_rready)
         st_next.bus.rvalid = 1'b0;
      rd_go = s_axi_arvalid && !st_reg.bus.rvalid;
      if (rd_go)
      begin
         ch  = s_axi_araddr[dcpwm_chan_bit];
         wd  = s_axi_araddr[4:2];
         st_next.bus.rvalid = 1'b1;
         st_next.bus.rresp  = 2'b00;
         if (s_axi_araddr == dcpwm_addr_status)
            rd = {25'h0,
                  st_reg.chan[1].overflow, st_reg.chan[1].done, st_reg.chan[1].running, 1'b0,
                  st_reg.chan[0].overflow, st_reg.chan[0].done, st_reg.chan[0].running};
         else if (s_axi_araddr[11:6] != 6'h0 || s_axi_araddr[1:0] != 2'b00)
            st_next.bus.rresp = 2'b10;
         else if (wd == dcpwm_off_freq_sel)
            rd = {16'h0, st_reg.chan[ch].freq_sel};
         else if (wd == dcpwm_off_duty)
            rd = {16'h0, st_reg.chan[ch].duty};
         else if (wd == dcpwm_off_cnt_en)
            rd = {16'h0, st_reg.chan[ch].cnt_en};
         else if (wd == dcpwm_off_pre_high)
            rd = {16'h0, st_reg.chan[ch].pre_high};
         else if (wd == dcpwm_off_pre_low)
            rd = {16'h0, st_reg.chan[ch].pre_low};
         else if (wd == dcpwm_off_cur_high)
            rd = {16'h0, st_reg.chan[ch].cur_count[31:16]};
         else if (wd == dcpwm_off_cur_low)
            rd = {16'h0, st_reg.chan[ch].cur_count[15:0]};
         else
            rd = {16'h0, 16'(st_reg.chan[ch].err)};
         st_next.bus.rdata = rd;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         st_reg <= '0;
         st_reg.chan[0].state <= dcpwm_idle;
         st_reg.chan[1].state <= dcpwm_idle;
         st_reg.chan[0].err   <= dcpwm_err_none;
         st_reg.chan[1].err   <= dcpwm_err_none;
      end
      else
         st_reg <= st_next;
   end

   // ==========================================================
   // Outputs
   // channel to output routing
   assign first_pulse_output  = st_reg.chan[0].pulse_out;
   assign second_pulse_output = st_reg.chan[1].pulse_out;
   assign running_flag  = {st_reg.chan[1].running, st_reg.chan[0].running};
   assign done_flag     = {st_reg.chan[1].done, st_reg.chan[0].done};
   assign overflow_flag = {st_reg.chan[1].overflow, st_reg.chan[0].overflow};
   assign s_axi_awready = !st_reg.bus.aw_held;
   assign s_axi_wready  = !st_reg.bus.w_held;
   assign s_axi_bvalid  = st_reg.bus.bvalid;
   assign s_axi_bresp   = st_reg.bus.bresp;
   assign s_axi_arready = !st_reg.bus.rvalid;
   assign s_axi_rvalid  = st_reg.bus.rvalid;
   assign s_axi_rdata   = st_reg.bus.rdata;
   assign s_axi_rresp   = st_reg.bus.rresp;

endmodule

// File: tb/dcpwm_checker.sv
// Port assertions for the dual channel pulse generator
`timescale 1ns/1ps
module dcpwm_checker
   import dcpwm_pkg::*;
(
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       reset,
   // Channel side
   input wire logic [1:0] start_in,
   input wire logic       first_pulse_output,
   input wire logic       second_pulse_output,
   input wire logic [1:0] running_flag,
   input wire logic [1:0] done_flag,
   input wire logic [1:0] overflow_flag,
   // Bus handshakes
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   // ==========================================================
   // Channel behaviour
   a_first_idle_low: assert property (!running_flag[0] && !$past(running_flag[0]) |-> !first_pulse_output)
      else $error("First output high while idle");
   a_second_idle_low: assert property (!running_flag[1] && !$past(running_flag[1]) |-> !second_pulse_output)
      else $error("Second output high while idle");
   a_stop_on_release: assert property ($fell(start_in[0]) |-> ##[1:2] (!first_pulse_output && !running_flag[0]))
      else $error("First channel kept running after start removal");
   a_done_on_stop: assert property ($fell(running_flag[0]) |-> ##[0:1] done_flag[0])
      else $error("Done flag missing after stop");
   a_done_clear_start: assert property ($rose(start_in[1]) |-> ##[1:3] !done_flag[1])
      else $error("Done flag not cleared by start");
   a_run_needs_start: assert property (running_flag[1] |-> $past(start_in[1]) || $past(start_in[1], 2))
      else $error("Second channel running without start");
   a_ovf_clear_start: assert property ($rose(start_in[0]) |-> ##[1:3] !overflow_flag[0])
      else $error("Overflow flag not cleared by start");
   a_second_no_ovf: assert property (!overflow_flag[1])
      else $error("Second channel overflow set");
   // ==========================================================
   // Register bus
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("Write response late");
   a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("Write response repeated");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("Write response withdrawn before taken");
   c_first_done: cover property ($rose(done_flag[0]));
   c_second_run: cover property ($rose(running_flag[1]));
   c_read_data: cover property (s_axi_rvalid && s_axi_bready == 1'b0);
endmodule

bind dcpwm_top dcpwm_checker i_dcpwm_checker (.sys_clk, .reset, .start_in, .first_pulse_output, .second_pulse_output,
   .running_flag, .done_flag, .overflow_flag, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// File: tb/dcpwm_load.sv
// Load model on the two pulse outputs: measures high widths
`timescale 1ns/1ps
module dcpwm_load
   import dcpwm_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // Pulse outputs under load
   input  wire logic [1:0]  pulse_in,
   // Measurements
   output logic [1:0][31:0] high_len,
   output logic [1:0][31:0] fall_cnt
);
   logic [1:0][31:0] run_len;
   always_ff @(posedge sys_clk)
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (reset)
         begin
            run_len[i]  <= 32'h0;
            high_len[i] <= 32'h0;
            fall_cnt[i] <= 32'h0;
         end
         else if (pulse_in[i])
         begin
            run_len[i] <= run_len[i] + 32'h1;
         end
         else if (run_len[i] != 32'h0)
         begin
            high_len[i] <= run_len[i];
            fall_cnt[i] <= fall_cnt[i] + 32'h1;
            run_len[i]  <= 32'h0;
         end
      end
   end
endmodule

// File: tb/dcpwm_top_tb.sv
// Self-checking bench for the dual channel pulse generator
`timescale 1ns/1ps
module dcpwm_top_tb
   import dcpwm_pkg::*;
;
   // ==========================================================
   // Signals
   logic             sys_clk;
   logic             reset         = 1'b1;
   logic [1:0]       start_in      = 2'b00;
   logic             s_axi_awvalid = 1'b0;
   logic [11:0]      s_axi_awaddr  = 12'h000;
   logic             s_axi_wvalid  = 1'b0;
   logic [31:0]      s_axi_wdata   = 32'h0;
   logic             s_axi_bready  = 1'b0;
   logic             s_axi_arvalid = 1'b0;
   logic [11:0]      s_axi_araddr  = 12'h000;
   logic             s_axi_rready  = 1'b0;
   logic             first_pulse_output, second_pulse_output, s_axi_awready, s_axi_wready;
   logic             s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]       running_flag, done_flag, overflow_flag, s_axi_bresp, s_axi_rresp;
   logic [31:0]      s_axi_rdata;
   logic [1:0][31:0] high_len, fall_cnt;
   int               miscompares   = 0;
   int               cmp_count     = 0;

   dcpwm_top i_dcpwm_top (.sys_clk, .reset, .start_in, .first_pulse_output, .second_pulse_output, .running_flag,
      .done_flag, .overflow_flag, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
   dcpwm_load i_dcpwm_load (.sys_clk, .reset, .pulse_in({second_pulse_output, first_pulse_output}), .high_len,
      .fall_cnt);

   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // Helpers
   task automatic tally_and_finish();
      if (miscompares == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic give_up();
      miscompares++;
      tally_and_finish();
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [11:0] ad(input logic c, input logic [2:0] o);
      return {6'h00, c, o, 2'b00};
   endfunction

   function automatic logic [2:0] st(input int c);
      return {c ? second_pulse_output : first_pulse_output, running_flag[c], done_flag[c]};
   endfunction

   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic [1:0] t;
      logic       b;
      @(posedge sys_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (int i = 0; i < 100; i++)
      begin
         @(negedge sys_clk);
         t = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready};
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge sys_clk);
         if (t[1])
            s_axi_awvalid <= 1'b0;
         if (t[0])
            s_axi_wvalid <= 1'b0;
         if (b)
         begin
            s_axi_bready <= 1'b0;
            return;
         end
      end
      give_up();
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic t;
      logic b;
      @(posedge sys_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (int i = 0; i < 100; i++)
      begin
         @(negedge sys_clk);
         t = s_axi_arvalid && s_axi_arready;
         b = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge sys_clk);
         if (t)
            s_axi_arvalid <= 1'b0;
         if (b)
         begin
            s_axi_rready <= 1'b0;
            return;
         end
      end
      give_up();
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
      logic [1:0] r;
      axi_write(a, d, r);
      check(32'(r), 32'(e));
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      check(d, e);
      check(32'(r), 32'(er));
   endtask

   task automatic prog(input logic c, input logic [15:0] f, du, ce, ph, pl);
      wr(ad(c, dcpwm_off_freq_sel), {16'h0, f}, 2'b00);
      wr(ad(c, dcpwm_off_duty), {16'h0, du}, 2'b00);
      wr(ad(c, dcpwm_off_cnt_en), {16'h0, ce}, 2'b00);
      wr(ad(c, dcpwm_off_pre_high), {16'h0, ph}, 2'b00);
      wr(ad(c, dcpwm_off_pre_low), {16'h0, pl}, 2'b00);
   endtask

   task automatic go(input int c, input logic v);
      @(posedge sys_clk);
      start_in[c] <= v;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   // ==========================================================
   // Scenarios
   task automatic sc_reset_map();
      for (int k = 0; k < 16; k++)
         rd(12'(k * 4), 32'h0, 2'b00);
      rd(dcpwm_addr_status, 32'h0, 2'b00);
      rd(12'h044, 32'h0, 2'b10);
      wr(12'h048, 32'h0, 2'b10);
      prog(1'b0, 16'h2, 16'h1, 16'h0, 16'h05f5, 16'he100);
      rd(ad(1'b0, dcpwm_off_pre_high), 32'h05f5, 2'b00);
      rd(ad(1'b0, dcpwm_off_pre_low), 32'he100, 2'b00);
      for (int k = 5; k < 8; k++)
      begin
         wr(ad(1'b0, 3'(k)), 32'hffff, 2'b00);
         rd(ad(1'b0, 3'(k)), 32'h0, 2'b00);
      end
   endtask

   task automatic sc_errors();
      logic [6:0][15:0] row [8] = '{
         {16'h0, 16'h3, 16'h32, 16'h0, 16'h0, 16'h0, 16'h1}, {16'h0, 16'h2, 16'h0, 16'h0, 16'h0, 16'h0, 16'h2},
         {16'h0, 16'h2, 16'h65, 16'h0, 16'h0, 16'h0, 16'h2}, {16'h0, 16'h2, 16'h32, 16'h2, 16'h0, 16'h0, 16'h3},
         {16'h0, 16'h2, 16'h32, 16'h1, 16'h0, 16'h0, 16'h4}, {16'h0, 16'h2, 16'h32, 16'h1, 16'h05f5, 16'he101, 16'h4},
         {16'h1, 16'h2, 16'h32, 16'h1, 16'h0, 16'h0, 16'h5}, {16'h0, 16'h2, 16'h32, 16'h1, 16'h05f5, 16'he100, 16'h0}};
      int c;
      for (int k = 0; k < 8; k++)
      begin
         c = int'(row[k][6][0]);
         prog(row[k][6][0], row[k][5], row[k][4], row[k][3], row[k][2], row[k][1]);
         go(c, 1'b1);
         repeat (4) @(posedge sys_clk);
         rd(ad(row[k][6][0], dcpwm_off_err), 32'(row[k][0]), 2'b00);
         @(negedge sys_clk);
         check(32'(st(c) >> 1), (row[k][0] == 16'h0) ? 32'h3 : 32'h0);
         go(c, 1'b0);
         repeat (4) @(posedge sys_clk);
      end
   endtask

   task automatic sc_duty_one();
      logic [22:0] per [3];
      logic [31:0] d;
      logic [1:0]  r;
      logic [31:0] f0;
      per = '{dcpwm_period0_cyc, dcpwm_period1_cyc, dcpwm_period2_cyc};
      for (int f = 0; f < 3; f++)
      begin
         prog(1'b0, 16'(f), 16'h1, 16'h0, 16'h0, 16'h0);
         go(0, 1'b1);
         repeat (4) @(posedge sys_clk);
         axi_read(dcpwm_addr_status, d, r);
         check(d & 32'h7, 32'h1);
         f0 = fall_cnt[0];
         for (int i = 0; i < 70000 && fall_cnt[0] == f0; i++)
            @(negedge sys_clk);
         if (fall_cnt[0] == f0)
            give_up();
         check(high_len[0], 32'(per[f] / 23'h64));
         check(32'(second_pulse_output), 32'h0);
         go(0, 1'b0);
         settle(3);
         check(32'(st(0)), 32'h1);
      end
   endtask

   task automatic sc_full_duty();
      prog(1'b1, 16'h2, 16'h64, 16'h0, 16'h0, 16'h0);
      go(1, 1'b1);
      settle(3000);
      check(32'(st(1)), 32'h6);
      check(32'(first_pulse_output), 32'h0);
      go(1, 1'b0);
      settle(2);
      check(32'(st(1)), 32'h1);
      go(1, 1'b1);
      settle(4);
      check(32'(st(1)), 32'h6);
      go(1, 1'b0);
   endtask

   initial
   begin
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      sc_reset_map();
      sc_errors();
      sc_duty_one();
      sc_full_duty();
      tally_and_finish();
   end
endmodule
